// File: ssrc_pkg.sv
// Purpose: shared constants and carrier types for the secure supply / random control block
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   register value sits in the low byte; upper bits read as zero
package ssrc_pkg;
	// register word indices (printed offsets are not multiples of four)
	localparam logic [15:0] SSRC_IDX_RNG_DATA = 16'h6105;
	localparam logic [15:0] SSRC_IDX_CTRL     = 16'h6106;
	localparam logic [15:0] SSRC_IDX_IRQ_STAT = 16'h6110;
	localparam logic [15:0] SSRC_IDX_IRQ_CLR  = 16'h6111;
	localparam logic [15:0] SSRC_IDX_IRQ_EN   = 16'h6112;
	// control register field positions
	localparam int SSRC_BIT_RSVD0     = 0;
	localparam int SSRC_BIT_RNG_VALID = 1;
	localparam int SSRC_BIT_RNG_FORCE = 2;
	localparam int SSRC_BIT_LIM_OFF   = 3;
	localparam int SSRC_BIT_SUP_EN    = 4;
	localparam int SSRC_BIT_OVERLOAD  = 5;
	localparam int SSRC_BIT_IN_MASK   = 6;
	localparam int SSRC_BIT_RSVD7     = 7;
	// reset values
	localparam logic       SSRC_RST_IN_MASK = 1'h1;
	localparam logic       SSRC_RST_RSVD0   = 1'h1;
	localparam logic [1:0] SSRC_RST_IRQ_EN  = 2'h0;
	// interrupt status layout
	localparam int SSRC_IRQ_OVERLOAD = 0;
	localparam int SSRC_IRQ_RNG_NEW  = 1;
	localparam int SSRC_NUM_IRQ      = 2;
	// fields software can write
	typedef struct packed {
		logic in_mask;
		logic sup_en;
		logic lim_off;
		logic rng_force;
	} ssrc_ctrl_t;
	// wishbone request
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [17:0] adr;
		logic [31:0] dat;
	} ssrc_wb_req_t;
endpackage : ssrc_pkg

// File: ssrc_sync.sv
// Purpose: two-flop synchroniser for pad and analog status inputs
// Assumes: inputs asynchronous to clk_i
// Notes:   only the second stage is visible outside
module ssrc_sync
	import ssrc_pkg::*;
#(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// data
	input  wire logic [W-1:0] d_i,
	output logic [W-1:0]      q_o
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : ssrc_sync

// File: ssrc_irq.sv
// Purpose: sticky event status, write-one clear and enable for one level interrupt
// Assumes: events are single-cycle pulses in the clk_i domain
// Notes:   a new event wins over a clear in the same cycle
module ssrc_irq
	import ssrc_pkg::*;
(
	// clock and reset
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	// events and software access
	input  wire logic [SSRC_NUM_IRQ-1:0] event_i,
	input  wire logic [SSRC_NUM_IRQ-1:0] clear_i,
	input  wire logic [SSRC_NUM_IRQ-1:0] enable_i,
	// results
	output logic [SSRC_NUM_IRQ-1:0]      status_o,
	output logic                         irq_o
);
	// set beats clear so no event is lost
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_o <= '0;
		end else begin
			status_o <= (status_o & ~clear_i) | event_i;
		end
	end

	assign irq_o = |(status_o & enable_i);
endmodule : ssrc_irq

// File: ssrc_top.sv
// Purpose: secure supply switch and random generator control register behind wishbone
// Assumes: analog switch, limiter and rng live outside; pads arrive asynchronously
// Notes:   one word per register index, byte address is four times the index
module ssrc_top
	import ssrc_pkg::*;
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [17:0] wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	// supply switch and regulator
	output logic             supply_en_o,
	output logic             supply_gnd_o,
	output logic             pads_powered_o,
	output logic             inrush_limit_o,
	input  wire logic        overload_i,
	// secure link inputs
	input  wire logic        secure_link_input_i,
	input  wire logic        port3_bit4_pin_i,
	output logic             secure_link_input_o,
	output logic             port3_bit4_pin_o,
	// random generator
	input  wire logic        contactless_interface_unit_rng_req_i,
	output logic             rng_run_o,
	input  wire logic        rng_new_i,
	input  wire logic [7:0]  rng_value_i,
	// interrupt
	output logic             irq_o
);
	ssrc_wb_req_t            req;
	ssrc_ctrl_t              ctrl;
	logic                    rng_valid;
	logic [7:0]              rng_data;
	logic [1:0]              pads_s;
	logic                    overload_s;
	logic                    overload_d;
	logic [15:0]             idx;
	logic                    acc;
	logic                    mapped;
	logic                    wr_ctrl;
	logic                    wr_clr;
	logic                    wr_en;
	logic                    rd_data;
	logic [SSRC_NUM_IRQ-1:0] irq_en;
	logic [SSRC_NUM_IRQ-1:0] irq_stat;
	logic [SSRC_NUM_IRQ-1:0] irq_evt;
	logic [SSRC_NUM_IRQ-1:0] irq_clr;
	logic [7:0]              ctrl_rd;
	logic [31:0]             next_dat;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

	// pad and limiter inputs come from other domains
	ssrc_sync #(.W(3)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({overload_i, secure_link_input_i, port3_bit4_pin_i}),
		.q_o   ({overload_s, pads_s})
	);

	// access timing, one wait-free answer:
	//   taking edge: cyc and stb high, ack and err low; a write lands here
	//   next edge:   ack (or err) sampled high, read data stands with it
	//   edge after:  ack low again; a held request is not taken twice,
	//                since acc is gated by the pending answer
	// no wait states, so a master may release as soon as it sees ack
	// address decode; low two byte address bits ignored
	assign idx     = req.adr[17:2];
	assign acc     = req.cyc & req.stb & ~wb_ack_o & ~wb_err_o;
	assign mapped  = (idx == SSRC_IDX_CTRL) | (idx == SSRC_IDX_RNG_DATA) | (idx == SSRC_IDX_IRQ_STAT)
	               | (idx == SSRC_IDX_IRQ_CLR) | (idx == SSRC_IDX_IRQ_EN);
	assign wr_ctrl = acc & req.we & req.sel[0] & (idx == SSRC_IDX_CTRL);
	assign wr_clr  = acc & req.we & req.sel[0] & (idx == SSRC_IDX_IRQ_CLR);
	assign wr_en   = acc & req.we & req.sel[0] & (idx == SSRC_IDX_IRQ_EN);
	assign rd_data = acc & ~req.we & (idx == SSRC_IDX_RNG_DATA);

	// one wait-free answer: ack or err a cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
		end else begin
			wb_ack_o <= acc & mapped;
			wb_err_o <= acc & ~mapped;
		end
	end

	// writable control fields; status and reserved bits are not stored here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl           <= '0;
			ctrl.in_mask   <= SSRC_RST_IN_MASK;
		end else if (wr_ctrl) begin
			ctrl.in_mask   <= req.dat[SSRC_BIT_IN_MASK];
			ctrl.sup_en    <= req.dat[SSRC_BIT_SUP_EN];
			ctrl.lim_off   <= req.dat[SSRC_BIT_LIM_OFF];
			ctrl.rng_force <= req.dat[SSRC_BIT_RNG_FORCE];
		end
	end

	// random value latch and ready flag; a fresh value wins over a read clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rng_valid <= 1'b0;
			rng_data  <= 8'h00;
		end else begin
			if (rng_new_i) begin
				rng_data  <= rng_value_i;
				rng_valid <= 1'b1;
			end else if (rd_data) begin
				rng_valid <= 1'b0;
			end
		end
	end

	// limiter edge for the interrupt
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overload_d <= 1'b0;
		end else begin
			overload_d <= overload_s;
		end
	end

	// interrupt enable register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_en <= SSRC_RST_IRQ_EN;
		end else if (wr_en) begin
			irq_en <= req.dat[SSRC_NUM_IRQ-1:0];
		end
	end

	// interrupt events: limiter rising edge and each new random value
	assign irq_evt[SSRC_IRQ_OVERLOAD] = overload_s & ~overload_d;
	assign irq_evt[SSRC_IRQ_RNG_NEW]  = rng_new_i;
	assign irq_clr = wr_clr ? req.dat[SSRC_NUM_IRQ-1:0] : '0;

	ssrc_irq u_irq (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.event_i  (irq_evt),
		.clear_i  (irq_clr),
		.enable_i (irq_en),
		.status_o (irq_stat),
		.irq_o    (irq_o)
	);

	// control register read image
	always_comb begin
		ctrl_rd                     = 8'h00;
		ctrl_rd[SSRC_BIT_RSVD7]     = 1'b0;
		ctrl_rd[SSRC_BIT_IN_MASK]   = ctrl.in_mask;
		ctrl_rd[SSRC_BIT_OVERLOAD]  = overload_s;
		ctrl_rd[SSRC_BIT_SUP_EN]    = ctrl.sup_en;
		ctrl_rd[SSRC_BIT_LIM_OFF]   = ctrl.lim_off;
		ctrl_rd[SSRC_BIT_RNG_FORCE] = ctrl.rng_force;
		ctrl_rd[SSRC_BIT_RNG_VALID] = rng_valid;
		ctrl_rd[SSRC_BIT_RSVD0]     = SSRC_RST_RSVD0;
	end

	// read mux; write-only clear reads as zero
	always_comb begin
		next_dat = 32'h0000_0000;
		unique case (idx)
			SSRC_IDX_CTRL:     next_dat[7:0] = ctrl_rd;
			SSRC_IDX_RNG_DATA: next_dat[7:0] = rng_data;
			SSRC_IDX_IRQ_STAT: next_dat[SSRC_NUM_IRQ-1:0] = irq_stat;
			SSRC_IDX_IRQ_EN:   next_dat[SSRC_NUM_IRQ-1:0] = irq_en;
			default:           next_dat = 32'h0000_0000;
		endcase
	end

	// read data registered with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (acc & ~req.we) begin
			wb_dat_o <= next_dat;
		end
	end

	// supply switch; disabled means pin pulled to ground
	assign supply_en_o    = ctrl.sup_en;
	assign pads_powered_o = ctrl.sup_en;
	assign supply_gnd_o   = ~ctrl.sup_en;
	assign inrush_limit_o = ~ctrl.lim_off;

	// masking holds inputs idle while the supply ramps
	assign secure_link_input_o = ctrl.in_mask ? 1'b0 : pads_s[1];
	assign port3_bit4_pin_o    = ctrl.in_mask ? 1'b1 : pads_s[0];

	// rng run request
	assign rng_run_o = ctrl.rng_force | contactless_interface_unit_rng_req_i;

	// checks
	ctrl_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl |=> (ctrl.sup_en == $past(req.dat[SSRC_BIT_SUP_EN])))
		else $error("control write not stored");
	limit_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_rd[SSRC_BIT_LIM_OFF] |-> inrush_limit_o)
		else $error("current limit dropped");
	supply_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl_rd[SSRC_BIT_SUP_EN] |-> (supply_gnd_o && !supply_en_o))
		else $error("supply not grounded");
	supply_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl_rd[SSRC_BIT_SUP_EN] |-> (supply_en_o && pads_powered_o && !supply_gnd_o))
		else $error("supply not on");
	overload_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(overload_i) ##2 overload_i |-> ctrl_rd[SSRC_BIT_OVERLOAD])
		else $error("overload not shown");
	mask_pass_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!ctrl.in_mask |-> (port3_bit4_pin_o == pads_s[0] && secure_link_input_o == pads_s[1]))
		else $error("pad not passed");
	mask_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.in_mask |-> (!secure_link_input_o && port3_bit4_pin_o))
		else $error("masked inputs wrong");
	rng_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(!ctrl.rng_force && !contactless_interface_unit_rng_req_i) |-> !rng_run_o)
		else $error("rng ran unrequested");
	rng_force_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctrl.rng_force |-> rng_run_o)
		else $error("rng not forced");
	rng_ready_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rng_new_i |=> (rng_valid && rng_data == $past(rng_value_i)))
		else $error("random ready not set");
	rng_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(rd_data && !rng_new_i) |=> !rng_valid)
		else $error("ready not cleared on read");
	rsvd_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl |=> (ctrl_rd[SSRC_BIT_RSVD0] && !ctrl_rd[SSRC_BIT_RSVD7]))
		else $error("reserved bits changed");
	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc && mapped) |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle");

	// first edge after reset: idle values, supply off, inputs masked
	reset_vals_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> (ctrl.in_mask == SSRC_RST_IN_MASK && !ctrl.sup_en && !ctrl.lim_off && !ctrl.rng_force
		&& !rng_valid && irq_stat == '0 && irq_en == SSRC_RST_IRQ_EN && !wb_ack_o && !wb_err_o))
		else $error("reset state wrong");

	// bus answer: one pulse, never both, nothing stored on a refused access
	err_unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc && !mapped) |=> (wb_err_o && !wb_ack_o))
		else $error("unmapped access not refused");
	err_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_err_o |=> !wb_err_o)
		else $error("err longer than one cycle");
	resp_excl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wb_ack_o && wb_err_o))
		else $error("ack and err together");
	unmapped_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc && !mapped) |=> (ctrl == $past(ctrl) && irq_en == $past(irq_en)))
		else $error("unmapped access changed state");
	sel_ignored_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc && req.we && !req.sel[0]) |=> (ctrl == $past(ctrl)))
		else $error("write without low byte stored");

	// read path: data taken at the ack edge and held until the next read
	read_ctrl_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(acc && !req.we && idx == SSRC_IDX_CTRL) |=> (wb_dat_o == {24'h000000, $past(ctrl_rd)}))
		else $error("control read data wrong");
	dat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!(acc && !req.we) |=> (wb_dat_o == $past(wb_dat_o)))
		else $error("read data moved without a read");
	rng_rd_dat_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_data |=> (wb_dat_o[7:0] == $past(rng_data)))
		else $error("random read data wrong");

	// supply and regulator follow the last control write; the overload bit follows the limiter
	lim_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctrl |=> (inrush_limit_o == !$past(req.dat[SSRC_BIT_LIM_OFF])))
		else $error("current limit not as written");
	gnd_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_ctrl && !req.dat[SSRC_BIT_SUP_EN]) |=> (supply_gnd_o && !supply_en_o && !pads_powered_o))
		else $error("supply off write not applied");
	pwr_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_ctrl && req.dat[SSRC_BIT_SUP_EN]) |=> (supply_en_o && pads_powered_o && !supply_gnd_o))
		else $error("supply on write not applied");
	overload_fall_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$fell(overload_i) ##2 !overload_i |-> !ctrl_rd[SSRC_BIT_OVERLOAD])
		else $error("overload shown after release");

	// link masking and random generator run
	mask_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_ctrl && req.dat[SSRC_BIT_IN_MASK]) |=> (!secure_link_input_o && port3_bit4_pin_o))
		else $error("mask write not applied");
	run_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
		contactless_interface_unit_rng_req_i |-> rng_run_o)
		else $error("rng request not passed");
	force_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_ctrl && req.dat[SSRC_BIT_RNG_FORCE]) |=> rng_run_o)
		else $error("force write not applied");

	// ready flag stays up until a read; software cannot write it
	rng_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(rng_valid && !rd_data) |=> rng_valid)
		else $error("ready dropped without a read");
	ready_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_ctrl && !rng_new_i && !rd_data) |=> (rng_valid == $past(rng_valid)))
		else $error("ready bit written");
	rng_data_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!rng_new_i |=> (rng_data == $past(rng_data)))
		else $error("random value changed alone");

	// interrupt status: edge sets, write-one clears, set wins
	rng_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rng_new_i |=> irq_stat[SSRC_IRQ_RNG_NEW])
		else $error("random event not latched");
	ovl_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(overload_s && !overload_d) |=> irq_stat[SSRC_IRQ_OVERLOAD])
		else $error("overload event not latched");
	irq_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_clr && req.dat[SSRC_IRQ_OVERLOAD] && !irq_evt[SSRC_IRQ_OVERLOAD]) |=> !irq_stat[SSRC_IRQ_OVERLOAD])
		else $error("status not cleared");
	irq_set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_evt != '0) |=> ((irq_stat & $past(irq_evt)) == $past(irq_evt)))
		else $error("event lost to clear");
	en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_en |=> (irq_en == $past(req.dat[SSRC_NUM_IRQ-1:0])))
		else $error("enable write not stored");
endmodule : ssrc_top

// File: ssrc_far.sv
// Purpose: far-side model: secure chip load, link pads and random source
// Assumes: levels from ssrc_top in the same clock domain
// Notes:   unpowered pads toggle, so a stale level can never pass a check
module ssrc_far (
	// clock
	input  wire logic       clk_i,
	// from the block
	input  wire logic       powered_i,
	input  wire logic       run_i,
	// scenario knobs
	input  wire logic [7:0] load_ma_i,
	input  wire logic       link_lvl_i,
	input  wire logic       port_lvl_i,
	// to the block
	output logic            overload_o,
	output logic            link_pad_o,
	output logic            port_pad_o,
	output logic            rng_new_o,
	output logic [7:0]      rng_value_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       toggle = 1'h0;
	logic [2:0] tick   = 3'h0;
	logic       fresh  = 1'h0;
	logic [7:0] value  = 8'h00;
	// one driver each: state starts known, outputs only mirror it
	assign rng_new_o   = fresh;
	assign rng_value_o = value;
	// limiter trips only above 40 mA on a live supply
	assign overload_o = powered_i && (load_ma_i > 8'h28);
	// floating pads: a changing level stands in for an unknown one
	always @(posedge clk_i) toggle <= ~toggle;
	assign link_pad_o = powered_i ? link_lvl_i : toggle;
	assign port_pad_o = powered_i ? port_lvl_i : ~toggle;
	// a fresh value every eight cycles while the generator runs
	always @(posedge clk_i) begin
		tick <= run_i ? tick + 3'h1 : 3'h0;
		fresh <= run_i && (tick == 3'h7);
		if (run_i && tick == 3'h7) value <= value + 8'h3B;
	end
endmodule : ssrc_far

// File: ssrc_top_tb.sv
// Purpose: self-checking bench for the supply / random control register
// Assumes: wishbone answers within a few cycles, pads pass two flops
// Notes:   read expectations queue up; a monitor compares at each ack
module ssrc_top_tb
	import ssrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic         clk_i = 1'h0;
	logic         rst_i = 1'h1;
	ssrc_wb_req_t req   = '0;
	logic         cu_req = 1'h0;
	logic         lnk    = 1'h0;
	logic         prt    = 1'h0;
	logic [7:0]   load   = 8'h00;
	logic [15:0]  lfsr   = 16'h000E;
	logic         got_err;
	logic [31:0]  exp_q[$];
	int           err_count = 0;
	int           num_checks = 0;
	wire  [31:0]  dat;
	wire          ack, err, sup, gnd, pwr, lim, ovl, lpad, ppad, link, port, run, rnew, irq;
	wire  [7:0]   rval;
	ssrc_top ssrc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
		.wb_we_i(req.we), .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(dat),
		.wb_ack_o(ack), .wb_err_o(err), .supply_en_o(sup), .supply_gnd_o(gnd), .pads_powered_o(pwr),
		.inrush_limit_o(lim), .overload_i(ovl), .secure_link_input_i(lpad), .port3_bit4_pin_i(ppad),
		.secure_link_input_o(link), .port3_bit4_pin_o(port), .contactless_interface_unit_rng_req_i(cu_req),
		.rng_run_o(run), .rng_new_i(rnew), .rng_value_i(rval), .irq_o(irq));
	ssrc_far ssrc_far_i (.clk_i(clk_i), .powered_i(pwr), .run_i(run), .load_ma_i(load), .link_lvl_i(lnk),
		.port_lvl_i(prt), .overload_o(ovl), .link_pad_o(lpad), .port_pad_o(ppad), .rng_new_o(rnew),
		.rng_value_o(rval));
	always #20 clk_i = ~clk_i;
	// compare task shared by every check
	task chk(input logic [31:0] seen, input logic [31:0] want);
		num_checks++;
		if (seen !== want) begin
			err_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, want);
		end
	endtask : chk
	// one classic cycle; the request holds until ack or err is sampled
	task bus(input logic w, input logic [15:0] idx, input logic [31:0] d, input logic s0, input logic [31:0] e);
		if (!w) exp_q.push_back(e);
		req <= '{cyc: 1'h1, stb: 1'h1, we: w, sel: (s0 ? 4'hF : 4'hE), adr: {idx, 2'h0}, dat: d};
		// no cycle count assumed; only the watchdog ends a hung wait
		do begin
			@(posedge clk_i);
		end while (ack !== 1'h1 && err !== 1'h1);
		got_err = (err === 1'h1);
		if (got_err && !w) void'(exp_q.pop_back());
		req <= '0;
		@(posedge clk_i);
	endtask : bus
	// read data is taken only at the acknowledging edge
	always @(posedge clk_i) if (ack === 1'h1 && !req.we && exp_q.size() > 0) chk(dat, exp_q.pop_front());
	// random source: 16-bit shift register, taps 16, 14, 13, 11
	function automatic logic [15:0] lfsr_next(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr_next
	function automatic logic [31:0] outs();
		return {25'h0, sup, pwr, gnd, lim, link, port, irq};
	endfunction : outs
	task final_report();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : final_report
	initial begin
		#(40 * 5000);
		err_count++;
		final_report();
	end
	initial begin
		logic [7:0] d;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		bus(1'h0, SSRC_IDX_CTRL, 32'h0, 1'h1, 32'h41);
		chk(outs(), 32'h1A);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			lfsr = lfsr_next(lfsr);
			d = lfsr[7:0] & 8'hFB;
			if (!d[4]) d[6] = 1'h1;
			lnk <= lfsr[8];
			prt <= lfsr[9];
			bus(1'h1, SSRC_IDX_CTRL, {24'h0, d}, 1'h1, 32'h0);
			repeat (4) @(posedge clk_i);
			bus(1'h0, SSRC_IDX_CTRL, 32'h0, 1'h1, {25'h0, d[6], 1'h0, d[4:3], 3'h1});
			chk(outs(), {25'h0, d[4], d[4], ~d[4], ~d[3], ~d[6] & lnk, d[6] | prt, 1'h0});
		end
		bus(1'h1, SSRC_IDX_CTRL, 32'hFF, 1'h0, 32'h0);
		bus(1'h0, SSRC_IDX_CTRL, 32'h0, 1'h1, {25'h0, d[6], 1'h0, d[4:3], 3'h1});
		$display("test random writes done");
		lnk <= 1'h1;
		prt <= 1'h0;
		bus(1'h1, SSRC_IDX_CTRL, 32'h10, 1'h1, 32'h0);
		bus(1'h1, SSRC_IDX_IRQ_EN, 32'h1, 1'h1, 32'h0);
		load <= 8'h29;
		repeat (4) @(posedge clk_i);
		chk({link, port}, {1'h1, prt});
		bus(1'h0, SSRC_IDX_CTRL, 32'h0, 1'h1, 32'h31);
		chk(irq, 1'h1);
		load <= 8'h28;
		repeat (4) @(posedge clk_i);
		bus(1'h0, SSRC_IDX_CTRL, 32'h0, 1'h1, 32'h11);
		bus(1'h1, SSRC_IDX_IRQ_EN, 32'h0, 1'h1, 32'h0);
		chk(irq, 1'h0);
		bus(1'h1, SSRC_IDX_IRQ_EN, 32'h1, 1'h1, 32'h0);
		chk(irq, 1'h1);
		bus(1'h1, SSRC_IDX_IRQ_CLR, 32'h1, 1'h1, 32'h0);
		chk(irq, 1'h0);
		bus(1'h0, SSRC_IDX_IRQ_STAT, 32'h0, 1'h1, 32'h0);
		$display("test overload done");
		cu_req <= 1'h1;
		@(posedge clk_i);
		chk(run, 1'h1);
		cu_req <= 1'h0;
		@(posedge clk_i);
		chk(run, 1'h0);
		bus(1'h1, SSRC_IDX_CTRL, 32'h54, 1'h1, 32'h0);
		chk(run, 1'h1);
		repeat (12) @(posedge clk_i);
		bus(1'h0, SSRC_IDX_CTRL, 32'h0, 1'h1, 32'h57);
		bus(1'h1, SSRC_IDX_CTRL, 32'h50, 1'h1, 32'h0);
		repeat (2) @(posedge clk_i);
		bus(1'h0, SSRC_IDX_RNG_DATA, 32'h0, 1'h1, {24'h0, rval});
		bus(1'h0, SSRC_IDX_CTRL, 32'h0, 1'h1, 32'h51);
		bus(1'h0, SSRC_IDX_IRQ_STAT, 32'h0, 1'h1, 32'h2);
		$display("test random generator done");
		bus(1'h1, 16'h0001, 32'hFF, 1'h1, 32'h0);
		chk(got_err, 1'h1);
		bus(1'h0, SSRC_IDX_CTRL, 32'h0, 1'h1, 32'h51);
		$display("test unmapped done");
		final_report();
	end
endmodule : ssrc_top_tb
